// >>> logic/pad_mux_pkg.sv
// Shared types and constants of the I/O pad signal multiplexer.
package pad_mux_pkg;

  // ==========================================================================
  // Pad counts and selection layout.
  localparam int PAD_COUNT_LARGE = 28;
  localparam int PAD_COUNT_SMALL = 12;
  localparam int GROUP_COUNT = 4;
  localparam int PAD_INDEX_W = 5;
  localparam int CODE_W = 5;
  localparam int GPIO_PORT_W = 8;
  localparam int GPIO_W = 40;
  localparam int HALF_OFFSET = 4;

  // ==========================================================================
  // Menu codes: 0..9 are port bits, port = code/2, upper half when code is odd.
  localparam logic [CODE_W-1:0] GPIO_CODE_LAST = 5'h09;
  localparam logic [CODE_W-1:0] FIFO_LO = 5'h0A;
  localparam logic [CODE_W-1:0] FIFO_HI = 5'h0B;
  localparam logic [CODE_W-1:0] PWM_LO = 5'h0C;
  localparam logic [CODE_W-1:0] PWM_HI = 5'h0D;
  localparam logic [CODE_W-1:0] G0_IN_DEBUG = 5'h0E;
  localparam logic [CODE_W-1:0] G0_IN_OE_N = 5'h0F;
  localparam logic [CODE_W-1:0] G0_IN_S0_CLK = 5'h10;
  localparam logic [CODE_W-1:0] G0_IN_S1_CLK = 5'h11;
  localparam logic [CODE_W-1:0] G0_OUT_DEBUG = 5'h0E;
  localparam logic [CODE_W-1:0] G0_OUT_TXD = 5'h0F;
  localparam logic [CODE_W-1:0] G0_OUT_DTR_N = 5'h10;
  localparam logic [CODE_W-1:0] G0_OUT_TX_ACTIVE = 5'h11;
  localparam logic [CODE_W-1:0] G0_OUT_RXF_N = 5'h12;
  localparam logic [CODE_W-1:0] G0_OUT_M_CLK = 5'h13;
  localparam logic [CODE_W-1:0] G0_OUT_M_SS1_N = 5'h14;
  localparam logic [CODE_W-1:0] G1_IN_RXD = 5'h0E;
  localparam logic [CODE_W-1:0] G1_IN_DSR_N = 5'h0F;
  localparam logic [CODE_W-1:0] G1_IN_S0_MO = 5'h10;
  localparam logic [CODE_W-1:0] G1_IN_S1_MO = 5'h11;
  localparam logic [CODE_W-1:0] G1_OUT_TXE_N = 5'h0E;
  localparam logic [CODE_W-1:0] G1_OUT_S0_MO = 5'h0F;
  localparam logic [CODE_W-1:0] G1_OUT_S1_MO = 5'h10;
  localparam logic [CODE_W-1:0] G1_OUT_M_MO = 5'h11;
  localparam logic [CODE_W-1:0] G1_OUT_FIFO_CLK = 5'h12;
  localparam logic [CODE_W-1:0] G2_IN_DCD_N = 5'h0E;
  localparam logic [CODE_W-1:0] G2_IN_RD_N = 5'h0F;
  localparam logic [CODE_W-1:0] G2_IN_M_MI = 5'h10;
  localparam logic [CODE_W-1:0] G2_OUT_RTS_N = 5'h0E;
  localparam logic [CODE_W-1:0] G2_OUT_S0_SO = 5'h0F;
  localparam logic [CODE_W-1:0] G2_OUT_S1_SO = 5'h10;
  localparam logic [CODE_W-1:0] G3_IN_CTS_N = 5'h0E;
  localparam logic [CODE_W-1:0] G3_IN_RI_N = 5'h0F;
  localparam logic [CODE_W-1:0] G3_IN_WR_N = 5'h10;
  localparam logic [CODE_W-1:0] G3_IN_S0_SEL_N = 5'h11;
  localparam logic [CODE_W-1:0] G3_IN_S1_SEL_N = 5'h12;
  localparam logic [CODE_W-1:0] G3_OUT_M_SS0_N = 5'h0E;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic isOutput;
    logic [CODE_W-1:0] code;
  } padSel_t;

  typedef struct packed {
    logic debugOut;
    logic txd;
    logic dtrN;
    logic txActive;
    logic rtsN;
    logic rxfN;
    logic txeN;
    logic fifoClkout;
    logic masterClock;
    logic masterOut;
    logic masterSelect0N;
    logic masterSelect1N;
    logic slave0SlaveOut;
    logic slave1SlaveOut;
    logic slave0MasterOut;
    logic slave1MasterOut;
    logic [7:0] fifoDataOut;
    logic [7:0] pwm;
    logic [GPIO_W-1:0] gpioOut;
  } periphOut_t;

  typedef struct packed {
    logic debugIn;
    logic rxd;
    logic ctsN;
    logic dsrN;
    logic ringIndicatorN;
    logic dcdN;
    logic wrN;
    logic rdN;
    logic oeN;
    logic slave0SerialClock;
    logic slave1SerialClock;
    logic slave0MasterOut;
    logic slave1MasterOut;
    logic slave0SelectN;
    logic slave1SelectN;
    logic masterIn;
    logic [7:0] fifoDataIn;
    logic [GPIO_W-1:0] gpioIn;
  } periphIn_t;

  localparam int IN_W = $bits(periphIn_t);

  // Levels of unrouted peripheral inputs: active-low lines high, others low.
  localparam periphIn_t IN_IDLE = '{ctsN: 1'b1, dsrN: 1'b1, ringIndicatorN: 1'b1,
    dcdN: 1'b1, wrN: 1'b1, rdN: 1'b1, oeN: 1'b1, slave0SelectN: 1'b1,
    slave1SelectN: 1'b1, default: '0};

endpackage : pad_mux_pkg

// >>> logic/pad_route.sv
// Menu decode of one pad: driven level, driver enable and input claim.
`timescale 1ns/1ps
module pad_route #(
  parameter int GROUP = 0
) (
  input wire pad_mux_pkg::padSel_t sel,
  input wire pad_mux_pkg::periphOut_t fromPeriph,
  output logic driveVal,
  output logic driveOeN,
  output pad_mux_pkg::periphIn_t claim
);
  import pad_mux_pkg::*;

  localparam logic [5:0] BIT_LO = 6'(GROUP);
  localparam logic [5:0] BIT_HI = 6'(GROUP + HALF_OFFSET);
  localparam logic [5:0] PORT_W = 6'(GPIO_PORT_W);

  logic [5:0] gpioIdx;

  assign gpioIdx = 6'(sel.code[4:1]) * PORT_W + (sel.code[0] ? BIT_HI : BIT_LO);

  always_comb begin
    driveVal = 1'b0;
    driveOeN = 1'b1;
    claim = '0;
    if (sel.isOutput) begin
      // The pad driver is enabled only for a valid output selection.
      driveOeN = 1'b0;
      if (sel.code <= GPIO_CODE_LAST) begin
        driveVal = fromPeriph.gpioOut[gpioIdx];
      end else if (sel.code == FIFO_LO) begin
        driveVal = fromPeriph.fifoDataOut[BIT_LO[2:0]];
      end else if (sel.code == FIFO_HI) begin
        driveVal = fromPeriph.fifoDataOut[BIT_HI[2:0]];
      end else if (sel.code == PWM_LO) begin
        driveVal = fromPeriph.pwm[BIT_LO[2:0]];
      end else if (sel.code == PWM_HI) begin
        driveVal = fromPeriph.pwm[BIT_HI[2:0]];
      end else if (GROUP == 0) begin
        case (sel.code)
          G0_OUT_DEBUG: driveVal = fromPeriph.debugOut;
          G0_OUT_TXD: driveVal = fromPeriph.txd;
          G0_OUT_DTR_N: driveVal = fromPeriph.dtrN;
          G0_OUT_TX_ACTIVE: driveVal = fromPeriph.txActive;
          G0_OUT_RXF_N: driveVal = fromPeriph.rxfN;
          G0_OUT_M_CLK: driveVal = fromPeriph.masterClock;
          G0_OUT_M_SS1_N: driveVal = fromPeriph.masterSelect1N;
          default: driveOeN = 1'b1;
        endcase
      end else if (GROUP == 1) begin
        case (sel.code)
          G1_OUT_TXE_N: driveVal = fromPeriph.txeN;
          G1_OUT_S0_MO: driveVal = fromPeriph.slave0MasterOut;
          G1_OUT_S1_MO: driveVal = fromPeriph.slave1MasterOut;
          G1_OUT_M_MO: driveVal = fromPeriph.masterOut;
          G1_OUT_FIFO_CLK: driveVal = fromPeriph.fifoClkout;
          default: driveOeN = 1'b1;
        endcase
      end else if (GROUP == 2) begin
        case (sel.code)
          G2_OUT_RTS_N: driveVal = fromPeriph.rtsN;
          G2_OUT_S0_SO: driveVal = fromPeriph.slave0SlaveOut;
          G2_OUT_S1_SO: driveVal = fromPeriph.slave1SlaveOut;
          default: driveOeN = 1'b1;
        endcase
      end else begin
        case (sel.code)
          G3_OUT_M_SS0_N: driveVal = fromPeriph.masterSelect0N;
          default: driveOeN = 1'b1;
        endcase
      end
    end else begin
      if (sel.code <= GPIO_CODE_LAST) begin
        claim.gpioIn[gpioIdx] = 1'b1;
      end else if (sel.code == FIFO_LO) begin
        claim.fifoDataIn[BIT_LO[2:0]] = 1'b1;
      end else if (sel.code == FIFO_HI) begin
        claim.fifoDataIn[BIT_HI[2:0]] = 1'b1;
      end else if (GROUP == 0) begin
        case (sel.code)
          G0_IN_DEBUG: claim.debugIn = 1'b1;
          G0_IN_OE_N: claim.oeN = 1'b1;
          G0_IN_S0_CLK: claim.slave0SerialClock = 1'b1;
          G0_IN_S1_CLK: claim.slave1SerialClock = 1'b1;
          default: claim = '0;
        endcase
      end else if (GROUP == 1) begin
        case (sel.code)
          G1_IN_RXD: claim.rxd = 1'b1;
          G1_IN_DSR_N: claim.dsrN = 1'b1;
          G1_IN_S0_MO: claim.slave0MasterOut = 1'b1;
          G1_IN_S1_MO: claim.slave1MasterOut = 1'b1;
          default: claim = '0;
        endcase
      end else if (GROUP == 2) begin
        case (sel.code)
          G2_IN_DCD_N: claim.dcdN = 1'b1;
          G2_IN_RD_N: claim.rdN = 1'b1;
          G2_IN_M_MI: claim.masterIn = 1'b1;
          default: claim = '0;
        endcase
      end else begin
        case (sel.code)
          G3_IN_CTS_N: claim.ctsN = 1'b1;
          G3_IN_RI_N: claim.ringIndicatorN = 1'b1;
          G3_IN_WR_N: claim.wrN = 1'b1;
          G3_IN_S0_SEL_N: claim.slave0SelectN = 1'b1;
          G3_IN_S1_SEL_N: claim.slave1SelectN = 1'b1;
          default: claim = '0;
        endcase
      end
    end
  end

endmodule : pad_route

// >>> logic/io_pad_signal_mux.sv
// Pad signal multiplexer: per-pad selection store, routing and pad drivers.
//
// Behaviour
// - Each pad independently picks from its group's menu.
// - Small package has twelve pads, 0 to 11.
// - Large package has twenty-eight pads, 0 to 27.
// - Hard reset loads fixed default selections.
// - Group 0 input menu feeds listed peripheral inputs.
// - Group 0 output menu drives listed signals.
// - Group 1 input menu feeds listed peripheral inputs.
// - Group 1 output menu drives listed signals.
// - Group 2 input menu feeds listed peripheral inputs.
// - Group 2 output menu drives listed signals.
// - Group 3 input menu feeds listed peripheral inputs.
// - Group 3 output menu drives listed signals.
// - Signals pass through without inversion.
`timescale 1ns/1ps
module io_pad_signal_mux #(
  parameter bit largePackage = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfgWrite,
  input wire logic [pad_mux_pkg::PAD_INDEX_W-1:0] cfgPad,
  input wire pad_mux_pkg::padSel_t cfgSel,
  input wire pad_mux_pkg::periphOut_t fromPeriph,
  input wire logic [pad_mux_pkg::PAD_COUNT_LARGE-1:0] padIn,
  output logic [pad_mux_pkg::PAD_COUNT_LARGE-1:0] padOut,
  output logic [pad_mux_pkg::PAD_COUNT_LARGE-1:0] padOeN,
  output pad_mux_pkg::periphIn_t toPeriph
);
  import pad_mux_pkg::*;

  localparam int PADS = PAD_COUNT_LARGE;
  localparam int PAD_COUNT = largePackage ? PAD_COUNT_LARGE : PAD_COUNT_SMALL;
  localparam logic [PAD_INDEX_W-1:0] PAD_LIMIT = PAD_INDEX_W'(PAD_COUNT);

  typedef struct packed {
    padSel_t [PADS-1:0] sel;
    logic [PADS-1:0] padOut;
    logic [PADS-1:0] padOeN;
    periphIn_t toPeriph;
    logic started;
  } muxState_t;

  // ==========================================================================
  // Reset state: every pad an input on a port bit, no driver enabled.
  function automatic logic [PADS*$bits(padSel_t)-1:0] defaultSel();
    padSel_t [PADS-1:0] s;
    for (int p = 0; p < PADS; p++) begin
      s[p].isOutput = 1'b0;
      s[p].code = CODE_W'(p / GROUP_COUNT);
    end
    return s;
  endfunction : defaultSel

  localparam muxState_t RESET_STATE = '{sel: defaultSel(), padOut: '0, padOeN: '1,
    toPeriph: IN_IDLE, started: 1'b0};

  muxState_t st_r;
  muxState_t st_nxt;
  logic [PADS-1:0] driveVal;
  logic [PADS-1:0] driveOeN;
  periphIn_t claim [PADS];
  periphIn_t anyClaim;

  // ==========================================================================
  // Per-pad menu decode.
  for (genvar p = 0; p < PADS; p++) begin : g_pad
    pad_route #(.GROUP(p % GROUP_COUNT)) u_route (
      .sel(st_r.sel[p]),
      .fromPeriph(fromPeriph),
      .driveVal(driveVal[p]),
      .driveOeN(driveOeN[p]),
      .claim(claim[p])
    );
  end

  always_comb begin
    anyClaim = '0;
    for (int p = 0; p < PAD_COUNT; p++) begin
      anyClaim = anyClaim | claim[p];
    end
  end

  // ==========================================================================
  // Next state. Where two pads claim one input, the lower pad wins.
  always_comb begin
    logic [IN_W-1:0] routed;
    routed = IN_IDLE;
    st_nxt = st_r;
    st_nxt.started = 1'b1;
    if (cfgWrite && cfgPad < PAD_LIMIT) begin
      st_nxt.sel[cfgPad] = cfgSel;
    end
    for (int p = PADS - 1; p >= 0; p--) begin
      if (p < PAD_COUNT) begin
        routed = (routed & ~claim[p]) | (claim[p] & {IN_W{padIn[p]}});
        st_nxt.padOut[p] = driveVal[p];
        st_nxt.padOeN[p] = driveOeN[p];
      end else begin
        st_nxt.padOut[p] = 1'b0;
        st_nxt.padOeN[p] = 1'b1;
      end
    end
    st_nxt.toPeriph = routed;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign padOut = st_r.padOut;
  assign padOeN = st_r.padOeN;
  assign toPeriph = st_r.toPeriph;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_write_pad0_out(logic [CODE_W-1:0] c);
    cfgWrite && cfgPad == '0 && cfgSel.isOutput && cfgSel.code == c;
  endsequence

  sequence s_pad0_driving;
    !padOeN[0];
  endsequence

  a_pad_write_stored: assert property (cfgWrite && cfgPad < PAD_LIMIT
    |=> st_r.sel[$past(cfgPad)] == $past(cfgSel))
    else $error("pad selection not stored");

  a_small_pads_idle: assert property (!largePackage |-> &padOeN[PADS-1:PAD_COUNT_SMALL])
    else $error("pad beyond small package drives");

  a_last_pad_drives: assert property (largePackage && cfgWrite && cfgPad == 5'h1B
    && cfgSel.isOutput && cfgSel.code == 5'h00 ##1 !cfgWrite |=> !padOeN[PADS-1])
    else $error("last large pad fails to drive");

  a_reset_defaults: assert property (!st_r.started |-> &padOeN &&
    st_r.sel == RESET_STATE.sel)
    else $error("defaults not loaded at reset");

  a_debug_in_route: assert property (!st_r.sel[0].isOutput &&
    st_r.sel[0].code == G0_IN_DEBUG |=> toPeriph.debugIn == $past(padIn[0]))
    else $error("debug input not routed from pad 0");

  a_pwm_out_route: assert property (s_write_pad0_out(PWM_HI) ##1 !cfgWrite
    |=> s_pad0_driving and padOut[0] == $past(fromPeriph.pwm[4]))
    else $error("pulse output 4 not on pad 0");

  a_rxd_in_route: assert property (!st_r.sel[1].isOutput &&
    st_r.sel[1].code == G1_IN_RXD && !claim[0].rxd |=> toPeriph.rxd == $past(padIn[1]))
    else $error("receive data not routed from pad 1");

  a_mosi_out_route: assert property (st_r.sel[1].isOutput &&
    st_r.sel[1].code == G1_OUT_S0_MO |=> !padOeN[1] &&
    padOut[1] == $past(fromPeriph.slave0MasterOut))
    else $error("slave 0 master-out not on pad 1");

  a_dcd_in_route: assert property (!st_r.sel[2].isOutput &&
    st_r.sel[2].code == G2_IN_DCD_N && !claim[0].dcdN && !claim[1].dcdN
    |=> toPeriph.dcdN == $past(padIn[2]))
    else $error("carrier detect not routed from pad 2");

  a_rts_out_route: assert property (st_r.sel[2].isOutput &&
    st_r.sel[2].code == G2_OUT_RTS_N |=> padOut[2] == $past(fromPeriph.rtsN))
    else $error("request-to-send altered on pad 2");

  a_ring_in_route: assert property (!st_r.sel[3].isOutput &&
    st_r.sel[3].code == G3_IN_RI_N && !claim[0].ringIndicatorN &&
    !claim[1].ringIndicatorN && !claim[2].ringIndicatorN
    |=> toPeriph.ringIndicatorN == $past(padIn[3]))
    else $error("ring indicator not routed from pad 3");

  a_ss0_out_route: assert property (st_r.sel[3].isOutput &&
    st_r.sel[3].code == G3_OUT_M_SS0_N |=> !padOeN[3] &&
    padOut[3] == $past(fromPeriph.masterSelect0N))
    else $error("master select 0 not on pad 3");

  a_input_no_drive: assert property (!st_r.sel[0].isOutput ##1 !st_r.sel[0].isOutput
    |-> padOeN[0])
    else $error("pad 0 driven while selected as input");

  a_unrouted_idle: assert property (!anyClaim.ctsN && !anyClaim.fifoDataIn[0]
    |=> toPeriph.ctsN && !toPeriph.fifoDataIn[0])
    else $error("unrouted input not at inactive level");

  // A write to a pad beyond the package count must leave every selection as it was.
  a_beyond_count_ignored: assert property (cfgWrite && cfgPad >= PAD_LIMIT
    |=> st_r.sel == $past(st_r.sel))
    else $error("write beyond pad count changed a selection");

  a_slave_clk_route: assert property (!st_r.sel[4].isOutput &&
    st_r.sel[4].code == G0_IN_S0_CLK && !claim[0].slave0SerialClock
    |=> toPeriph.slave0SerialClock == $past(padIn[4]))
    else $error("slave 0 clock not routed from pad 4");

  a_fifo_in_route: assert property (!st_r.sel[4].isOutput &&
    st_r.sel[4].code == FIFO_HI && !claim[0].fifoDataIn[4]
    |=> toPeriph.fifoDataIn[4] == $past(padIn[4]))
    else $error("parallel data bit 4 not routed from pad 4");

  a_gpio_out_route: assert property (st_r.sel[1].isOutput &&
    st_r.sel[1].code == 5'h09 |=> !padOeN[1] &&
    padOut[1] == $past(fromPeriph.gpioOut[4 * GPIO_PORT_W + 1 + HALF_OFFSET]))
    else $error("port bit not driven on pad 1");

  a_gpio_in_route: assert property (!st_r.sel[6].isOutput &&
    st_r.sel[6].code == 5'h03 && !claim[2].gpioIn[GPIO_PORT_W + 2 + HALF_OFFSET]
    |=> toPeriph.gpioIn[GPIO_PORT_W + 2 + HALF_OFFSET] == $past(padIn[6]))
    else $error("port bit not routed from pad 6");

  // Codes past the end of a group's output menu must leave the pad released.
  a_unknown_out_off: assert property (st_r.sel[8].isOutput &&
    st_r.sel[8].code > G0_OUT_M_SS1_N |=> padOeN[8])
    else $error("pad 8 driven by an unknown output code");

endmodule : io_pad_signal_mux

// >>> verif/pad_partner.sv
// Board and peripheral model: random peripheral outputs and board levels on released pads.
`timescale 1ns/1ps
module pad_partner (
  input wire logic clk,
  input wire logic [pad_mux_pkg::PAD_COUNT_LARGE-1:0] padOut,
  input wire logic [pad_mux_pkg::PAD_COUNT_LARGE-1:0] padOeN,
  output pad_mux_pkg::periphOut_t fromPeriph,
  output logic [pad_mux_pkg::PAD_COUNT_LARGE-1:0] padIn
);
  import pad_mux_pkg::*;
  integer seed = 41725;
  logic [127:0] r;
  logic [PAD_COUNT_LARGE-1:0] boardLvl = '0;
  initial fromPeriph = '0;
  // A pad that the device drives reads back its own level; a released pad shows the board.
  assign padIn = (padOut & ~padOeN) | (boardLvl & padOeN);
  always @(posedge clk) begin
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    fromPeriph <= r[$bits(periphOut_t)-1:0];
    boardLvl <= r[127:100];
  end
endmodule : pad_partner

// >>> verif/io_pad_signal_mux_bench.sv
// Self-checking bench of the pad multiplexer against a reference routing model.
`timescale 1ns/1ps
module io_pad_signal_mux_bench;
  import pad_mux_pkg::*;
  typedef padSel_t selTable_t [PAD_COUNT_LARGE];
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfgWrite = 1'b0;
  logic [PAD_INDEX_W-1:0] cfgPad = '0;
  padSel_t cfgSel = '0;
  periphOut_t fromPeriph, fpS;
  logic [PAD_COUNT_LARGE-1:0] padIn, piS, ePo, eOe;
  logic [PAD_COUNT_LARGE-1:0] padOut [2];
  logic [PAD_COUNT_LARGE-1:0] padOeN [2];
  periphIn_t toPeriph [2];
  periphIn_t eIn;
  selTable_t selM [2];
  int settle = 3;
  int failures = 0;
  int nCompared = 0;
  integer seed = 41725;

  io_pad_signal_mux #(.largePackage(1'b1)) dut (.clk(clk), .rst(rst), .cfgWrite(cfgWrite),
    .cfgPad(cfgPad), .cfgSel(cfgSel), .fromPeriph(fromPeriph), .padIn(padIn),
    .padOut(padOut[0]), .padOeN(padOeN[0]), .toPeriph(toPeriph[0]));
  io_pad_signal_mux #(.largePackage(1'b0)) dutSmall (.clk(clk), .rst(rst), .cfgWrite(cfgWrite),
    .cfgPad(cfgPad), .cfgSel(cfgSel), .fromPeriph(fromPeriph), .padIn(padIn),
    .padOut(padOut[1]), .padOeN(padOeN[1]), .toPeriph(toPeriph[1]));
  pad_partner partner (.clk(clk), .padOut(padOut[0]), .padOeN(padOeN[0]),
    .fromPeriph(fromPeriph), .padIn(padIn));

  initial begin
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Reference routing model.
  function automatic logic [1:0] outBit(periphOut_t f, int g, logic [CODE_W-1:0] c);
    int h;
    h = g + HALF_OFFSET * int'(c[0]);
    if (c <= GPIO_CODE_LAST) return {1'b1, f.gpioOut[int'(c[4:1]) * GPIO_PORT_W + h]};
    if (c == FIFO_LO || c == FIFO_HI) return {1'b1, f.fifoDataOut[h]};
    if (c == PWM_LO || c == PWM_HI) return {1'b1, f.pwm[h]};
    case ({g[1:0], c})
      {2'h0, G0_OUT_DEBUG}: return {1'b1, f.debugOut};
      {2'h0, G0_OUT_TXD}: return {1'b1, f.txd};
      {2'h0, G0_OUT_DTR_N}: return {1'b1, f.dtrN};
      {2'h0, G0_OUT_TX_ACTIVE}: return {1'b1, f.txActive};
      {2'h0, G0_OUT_RXF_N}: return {1'b1, f.rxfN};
      {2'h0, G0_OUT_M_CLK}: return {1'b1, f.masterClock};
      {2'h0, G0_OUT_M_SS1_N}: return {1'b1, f.masterSelect1N};
      {2'h1, G1_OUT_TXE_N}: return {1'b1, f.txeN};
      {2'h1, G1_OUT_S0_MO}: return {1'b1, f.slave0MasterOut};
      {2'h1, G1_OUT_S1_MO}: return {1'b1, f.slave1MasterOut};
      {2'h1, G1_OUT_M_MO}: return {1'b1, f.masterOut};
      {2'h1, G1_OUT_FIFO_CLK}: return {1'b1, f.fifoClkout};
      {2'h2, G2_OUT_RTS_N}: return {1'b1, f.rtsN};
      {2'h2, G2_OUT_S0_SO}: return {1'b1, f.slave0SlaveOut};
      {2'h2, G2_OUT_S1_SO}: return {1'b1, f.slave1SlaveOut};
      {2'h3, G3_OUT_M_SS0_N}: return {1'b1, f.masterSelect0N};
      default: return 2'h0;
    endcase
  endfunction : outBit

  function automatic void claim(inout periphIn_t t, input int g, input logic [CODE_W-1:0] c,
      input logic v);
    int h;
    h = g + HALF_OFFSET * int'(c[0]);
    if (c <= GPIO_CODE_LAST) t.gpioIn[int'(c[4:1]) * GPIO_PORT_W + h] = v;
    else if (c == FIFO_LO || c == FIFO_HI) t.fifoDataIn[h] = v;
    else case ({g[1:0], c})
      {2'h0, G0_IN_DEBUG}: t.debugIn = v;
      {2'h0, G0_IN_OE_N}: t.oeN = v;
      {2'h0, G0_IN_S0_CLK}: t.slave0SerialClock = v;
      {2'h0, G0_IN_S1_CLK}: t.slave1SerialClock = v;
      {2'h1, G1_IN_RXD}: t.rxd = v;
      {2'h1, G1_IN_DSR_N}: t.dsrN = v;
      {2'h1, G1_IN_S0_MO}: t.slave0MasterOut = v;
      {2'h1, G1_IN_S1_MO}: t.slave1MasterOut = v;
      {2'h2, G2_IN_DCD_N}: t.dcdN = v;
      {2'h2, G2_IN_RD_N}: t.rdN = v;
      {2'h2, G2_IN_M_MI}: t.masterIn = v;
      {2'h3, G3_IN_CTS_N}: t.ctsN = v;
      {2'h3, G3_IN_RI_N}: t.ringIndicatorN = v;
      {2'h3, G3_IN_WR_N}: t.wrN = v;
      {2'h3, G3_IN_S0_SEL_N}: t.slave0SelectN = v;
      {2'h3, G3_IN_S1_SEL_N}: t.slave1SelectN = v;
      default: ;
    endcase
  endfunction : claim

  // Pads are walked from the top down so that the lowest pad claiming an input wins.
  function automatic void route(input selTable_t s, input int n, input periphOut_t f,
      input logic [PAD_COUNT_LARGE-1:0] pin, output logic [PAD_COUNT_LARGE-1:0] po,
      output logic [PAD_COUNT_LARGE-1:0] oe, output periphIn_t t);
    logic [1:0] r;
    po = '0;
    oe = '1;
    t = IN_IDLE;
    for (int p = n - 1; p >= 0; p--) begin
      if (s[p].isOutput) begin
        r = outBit(f, p % GROUP_COUNT, s[p].code);
        oe[p] = ~r[1];
        po[p] = r[0];
      end else begin
        claim(t, p % GROUP_COUNT, s[p].code, pin[p]);
      end
    end
  endfunction : route

  // ==========================================================================
  // Model state and comparisons.
  always @(posedge clk) begin
    fpS <= fromPeriph;
    piS <= padIn;
    if (settle > 0) settle <= settle - 1;
    if (rst) begin
      settle <= 3;
      for (int p = 0; p < PAD_COUNT_LARGE; p++) begin
        selM[0][p] <= {1'b0, CODE_W'(p / 4)};
        selM[1][p] <= {1'b0, CODE_W'(p / 4)};
      end
    end else if (cfgWrite) begin
      settle <= 3;
      if (cfgPad < PAD_COUNT_LARGE) selM[0][cfgPad] <= cfgSel;
      if (cfgPad < PAD_COUNT_SMALL) selM[1][cfgPad] <= cfgSel;
    end
  end

  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        chk("drivers in reset", 128'(padOeN[i]), {128{1'b1}} >> 100);
        chk("inputs in reset", 128'(toPeriph[i]), 128'(IN_IDLE));
      end else if (settle == 0) begin
        route(selM[i], i ? PAD_COUNT_SMALL : PAD_COUNT_LARGE, fpS, piS, ePo, eOe, eIn);
        chk("drivers", 128'(padOeN[i]), 128'(eOe));
        chk("pad levels", 128'(padOut[i] & ~eOe), 128'(ePo & ~eOe));
        chk("inputs", 128'(toPeriph[i]), 128'(eIn));
      end
    end
  end

  // ==========================================================================
  // Stimulus.
  task automatic write(input logic [PAD_INDEX_W-1:0] p, input padSel_t s);
    cfgWrite <= 1'b1;
    cfgPad <= p;
    cfgSel <= s;
    @(posedge clk);
  endtask : write

  task automatic idle(input int n);
    cfgWrite <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic report_and_stop;
    $display("compared %0d failures %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    failures++;
    $display("timeout");
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    idle(20);
    $display("test defaults done");
    write(5'h00, {1'b0, G0_IN_DEBUG});
    write(5'h04, {1'b0, G0_IN_DEBUG});
    write(5'h1F, {1'b1, PWM_HI});
    write(5'h08, {1'b1, 5'h1F});
    write(5'h0D, {1'b0, PWM_LO});
    write(5'h0E, {1'b1, G2_OUT_RTS_N});
    write(5'h01, {1'b0, G1_IN_RXD});
    write(5'h02, {1'b0, G2_IN_DCD_N});
    write(5'h03, {1'b0, G3_IN_RI_N});
    write(5'h1B, {1'b1, 5'h00});
    idle(2);
    write(5'h00, {1'b1, PWM_HI});
    idle(10);
    $display("test corners done");
    for (int c = 0; c < 21; c++) begin
      for (int g = 0; g < GROUP_COUNT; g++) begin
        write(PAD_INDEX_W'(g), {1'b1, CODE_W'(c)});
        write(PAD_INDEX_W'(g + 4), {1'b0, CODE_W'(c)});
        write(PAD_INDEX_W'(g + 12), {1'b1, CODE_W'(c)});
      end
      idle(6);
    end
    $display("test menus done");
    for (int k = 0; k < 300; k++) begin
      write(PAD_INDEX_W'($random(seed)), padSel_t'(6'($random(seed))));
      idle(1 + ($random(seed) & 3));
    end
    idle(5);
    $display("test random done");
    rst <= 1'b1;
    idle(4);
    rst <= 1'b0;
    idle(20);
    $display("test second reset done");
    report_and_stop;
  end
endmodule : io_pad_signal_mux_bench
